// ---- fbc_consts.svh ----
// Purpose: Named offsets, masks, reset values and timing counts for the filter backend control block
// Assumes: Included by bare name after the guard
// Notes:   Definitions only
`ifndef FBC_CONSTS_SVH
`define FBC_CONSTS_SVH

// Host address map, byte-wide registers
`define FBC_ADDR_W        10
`define FBC_OFF_BE0       10'h0A0
`define FBC_OFF_BE1       10'h0A1
`define FBC_OFF_BE2       10'h0A2
`define FBC_OFF_BE3       10'h0A3
`define FBC_OFF_STAT      10'h0A8
`define FBC_OFF_ACT       10'h0A9

// Writable bits; reserved bits are stored as zero so they read back as zero
`define FBC_MASK_STAT     8'h3F
`define FBC_MASK_ACT      8'h03
`define FBC_MASK_BE0      8'hFF
`define FBC_MASK_BE1      8'h03
`define FBC_MASK_BE2      8'h7F
`define FBC_MASK_BE3      8'hFE

// Reset and idle values
`define FBC_RST_BYTE      8'h00
`define FBC_UNMAPPED_RD   8'h00

// Coefficient bank base addresses
`define FBC_BANK0_BASE    7'h00
`define FBC_BANK1_BASE    7'h40

// Output byte lanes of the cascade output
`define FBC_LO_LSB        0
`define FBC_HI_MSB        21

// Timing in clocks
`define FBC_CHAIN_DLY     2
`define FBC_WR_LAT_MAX    3

`endif

// ---- fbc_pkg.sv ----
// Purpose: Types shared by the filter backend control block
// Assumes: Constants live in fbc_consts.svh
// Notes:   Field order of each struct is the register bit order, msb first
package fbc_pkg;

  // Static configuration byte
  typedef struct packed {
    logic [1:0] rsv;
    logic       psr_oe;
    logic       cas_en;
    logic       coef_uns;
    logic       data_uns;
    logic       bypass;
    logic       swap;
  } fbc_stat_t;

  // Active control byte
  typedef struct packed {
    logic [5:0] rsv;
    logic       lut_en;
    logic       bank;
  } fbc_act_t;

  // Backend control bytes zero to three
  typedef struct packed {
    logic       full_wave;
    logic       half_wave;
    logic [4:0] scale;
    logic       cas_zero;
  } fbc_be0_t;

  typedef struct packed {
    logic [5:0] rsv;
    logic       static_thr;
    logic       greater;
  } fbc_be1_t;

  typedef struct packed {
    logic       rsv;
    logic       lo_pass;
    logic       hi_pass;
    logic [4:0] prescale;
  } fbc_be2_t;

  typedef struct packed {
    logic [4:0] norm;
    logic       norm_dyn;
    logic       lut_add;
    logic       rsv;
  } fbc_be3_t;

  // Host pin bundle, carried through the synchroniser as one word
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       en_n;
    logic       wr_n;
  } fbc_hreq_t;

endpackage

// ---- fbc_sync.sv ----
// Purpose: Two-flop synchroniser for a bundle of asynchronous pins
// Assumes: Each bit is treated on its own; bundle skew is absorbed by the caller
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module fbc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Two stages, constant reset value
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end

  assign o_q = sync_ff;
endmodule

// ---- fbc_backend.sv ----
// Purpose: Array output scaler, cascade adder input zeroing, cascade adder and rectifier
// Assumes: One result per valid mac word, same clock
// Notes:   Result is registered; overflow of the adder wraps
`timescale 1ns/1ns
module fbc_backend import fbc_pkg::*; #(
  parameter int AW = 24
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire fbc_be0_t      i_be0,
  input  wire logic [AW-1:0] i_mac,
  input  wire logic          i_mac_vld,
  input  wire logic [AW-1:0] i_cas_in,
  output logic      [AW-1:0] o_res,
  output logic               o_res_vld
);
  logic signed [AW-1:0] scaled;
  logic signed [AW-1:0] cas_sel;
  logic signed [AW-1:0] sum;
  logic signed [AW-1:0] rect;
  logic        [AW-1:0] res_ff;
  logic                 vld_ff;

  always_comb begin
    if (i_be0.scale[4]) begin
      scaled = $signed(i_mac) <<< 5'(~i_be0.scale + 5'h01);
    end else begin
      scaled = $signed(i_mac) >>> i_be0.scale;
    end
  end

  assign cas_sel = i_be0.cas_zero ? '0 : $signed(i_cas_in);
  assign sum     = scaled + cas_sel;

  // Full wave wins over half wave
  always_comb begin
    if (i_be0.full_wave) begin
      rect = sum[AW-1] ? -sum : sum;
    end else if (i_be0.half_wave && sum[AW-1]) begin
      rect = '0;
    end else begin
      rect = sum;
    end
  end

  // Result register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      res_ff <= '0;
      vld_ff <= 1'b0;
    end else begin
      res_ff <= rect;
      vld_ff <= i_mac_vld;
    end
  end

  assign o_res     = res_ff;
  assign o_res_vld = vld_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_full_wave;
    i_be0.full_wave && i_be0.cas_zero && i_be0.scale == 5'h00 && i_mac != {1'b1, {(AW-1){1'b0}}}
      |=> o_res == ($past(i_mac[AW-1]) ? AW'(-$past(i_mac)) : $past(i_mac));
  endproperty
  a_full_wave: assert property (p_full_wave) else $error("full wave result is not the absolute value");

  property p_half_wave;
    !i_be0.full_wave && i_be0.half_wave |=> !o_res[AW-1];
  endproperty
  a_half_wave: assert property (p_half_wave) else $error("half wave let a negative value through");

  property p_scale_right;
    i_be0 == 8'h05 |=> o_res == AW'($signed($past(i_mac)) >>> 2);
  endproperty
  a_scale_right: assert property (p_scale_right) else $error("scale of plus two did not quarter");

  property p_cas_zero;
    i_be0 == 8'h01 |=> o_res == $past(i_mac);
  endproperty
  a_cas_zero: assert property (p_cas_zero) else $error("cascade data reached the adder while zeroed");
endmodule

// ---- fbc_ctrl.sv ----
// Purpose: Control fields of a cascadable multiply-accumulate filter and its backend post-processing
// Assumes: Host pins are asynchronous; datapath inputs share I_MCLK
`timescale 1ns/1ns
`include "fbc_consts.svh"
module fbc_ctrl import fbc_pkg::*; #(
  parameter int AW = 24,
  parameter int CW = 22,
  parameter int HW = 22
) (
  input  wire logic          I_MCLK,
  input  wire logic          I_RST,
  input  wire logic [9:0]    I_HOST_ADDR,
  input  wire logic [7:0]    I_HOST_WDATA,
  input  wire logic          I_HOST_EN_N,
  input  wire logic          I_HOST_WR_N,
  output logic      [7:0]    O_HOST_RDATA,
  output logic               O_HOST_RDATA_OE,
  input  wire logic [7:0]    I_SAMPLE,
  input  wire logic          I_CYCLE_END,
  output logic      [8:0]    O_SAMPLE_EXT,
  input  wire logic          I_COEF_WR,
  input  wire logic [6:0]    I_COEF_ADDR,
  input  wire logic [7:0]    I_COEF,
  output logic               O_COEF_WR,
  output logic      [6:0]    O_COEF_ADDR,
  output logic      [8:0]    O_COEF_EXT,
  output logic               O_BANK,
  output logic      [6:0]    O_BANK_BASE,
  input  wire logic [7:0]    I_CHAIN_IN,
  input  wire logic [7:0]    I_PSR_LAST,
  output logic      [7:0]    O_CHAIN_OUT,
  output logic               O_CHAIN_OE,
  output logic               O_LUT_HOST_OWN,
  input  wire logic [7:0]    I_LUT_BYTE,
  input  wire logic [4:0]    I_LUT_NORM,
  output logic      [7:0]    O_LUT_XFORM,
  output logic      [4:0]    O_NORM_SHIFT,
  output logic               O_LUT_TO_ADDER,
  input  wire logic [AW-1:0] I_MAC,
  input  wire logic          I_MAC_VALID,
  input  wire logic [AW-1:0] I_CAS_IN,
  output logic      [CW-1:0] O_CAS,
  output logic               O_CAS_OE,
  input  wire logic          I_EXT_LOAD,
  input  wire logic [AW-1:0] I_EXT_VAL,
  output logic      [AW-1:0] O_EXTREME,
  output logic      [HW-1:0] O_HIT_COUNT
);
  localparam int WR_LAT_MAX = `FBC_WR_LAT_MAX;

  // Widths the output byte lanes and adder cannot serve
  if (CW != `FBC_HI_MSB + 1 || AW < CW) begin : g_bad_width
    $error("cascade width must be 22 and adder width at least that");
  end

  fbc_hreq_t pin_req;
  fbc_hreq_t req_s;
  fbc_hreq_t lat_ff;
  logic      en_q_ff;
  logic      wr_commit;
  logic      rd_act;
  logic [7:0] rdata_ff;
  logic      rd_oe_ff;
  logic [7:0] nxt_rdata;

  fbc_stat_t stat_ff;
  fbc_act_t  act_ff;
  fbc_be0_t  be0_ff;
  fbc_be1_t  be1_ff;
  fbc_be2_t  be2_ff;
  fbc_be3_t  be3_ff;
  logic      bank_ff;

  logic [8:0] coef_ff;
  logic [6:0] coef_addr_ff;
  logic       coef_wr_ff;
  logic [8:0] sample_ff;
  logic [7:0] chain_d1_ff;
  logic [7:0] chain_out_ff;
  logic [7:0] lut_x_ff;
  logic [4:0] norm_ff;
  logic       lut_add_ff;

  logic [AW-1:0] res;
  logic          res_vld;
  logic          cmp;
  logic          hit;
  logic [AW-1:0] ext_ff;
  logic [HW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cas;
  logic [CW-1:0] cas_ff;

  // Host pins pass two flops; idle level is enable high
  assign pin_req = '{addr: I_HOST_ADDR, wdata: I_HOST_WDATA, en_n: I_HOST_EN_N, wr_n: I_HOST_WR_N};

  fbc_sync #(
    .W       ($bits(fbc_hreq_t)),
    .RST_VAL ({10'h000, 8'h00, 1'b1, 1'b1})
  ) u_host_sync (
    .i_clk (I_MCLK),
    .i_rst (I_RST),
    .i_d   (pin_req),
    .o_q   (req_s)
  );

  // Hold the last sample taken while enabled; a write acts when enable rises
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      lat_ff  <= '{addr: 10'h000, wdata: 8'h00, en_n: 1'b1, wr_n: 1'b1};
      en_q_ff <= 1'b1;
    end else begin
      en_q_ff <= req_s.en_n;
      if (!req_s.en_n) begin
        lat_ff <= req_s;
      end
    end
  end

  // Commit on end of write cycle
  assign wr_commit = req_s.en_n && !en_q_ff && !lat_ff.wr_n;
  assign rd_act    = !req_s.en_n && req_s.wr_n;

  // Control fields, reserved bits masked off
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      stat_ff <= `FBC_RST_BYTE;
      be0_ff  <= `FBC_RST_BYTE;
      be1_ff  <= `FBC_RST_BYTE;
      be2_ff  <= `FBC_RST_BYTE;
      be3_ff  <= `FBC_RST_BYTE;
    end else if (wr_commit) begin
      unique case (lat_ff.addr)
        `FBC_OFF_STAT: stat_ff <= lat_ff.wdata & `FBC_MASK_STAT;
        `FBC_OFF_BE0:  be0_ff  <= lat_ff.wdata & `FBC_MASK_BE0;
        `FBC_OFF_BE1:  be1_ff  <= lat_ff.wdata & `FBC_MASK_BE1;
        `FBC_OFF_BE2:  be2_ff  <= lat_ff.wdata & `FBC_MASK_BE2;
        `FBC_OFF_BE3:  be3_ff  <= lat_ff.wdata & `FBC_MASK_BE3;
        default: ;
      endcase
    end
  end

  // Active control keeps only two bits
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      act_ff <= `FBC_RST_BYTE;
    end else if (wr_commit && lat_ff.addr == `FBC_OFF_ACT) begin
      act_ff <= lat_ff.wdata & `FBC_MASK_ACT;
    end
  end

  // Bank follows written bit, toggles per cycle in swap mode
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      bank_ff <= 1'b0;
    end else if (wr_commit && lat_ff.addr == `FBC_OFF_ACT) begin
      bank_ff <= lat_ff.wdata[0];
    end else if (stat_ff.swap && I_CYCLE_END) begin
      bank_ff <= !bank_ff;
    end
  end

  assign O_BANK = bank_ff;
  assign O_BANK_BASE = bank_ff ? `FBC_BANK1_BASE : `FBC_BANK0_BASE;

  // Read decode; reserved bits are stored zero, unmapped reads zero
  always_comb begin
    unique case (req_s.addr)
      `FBC_OFF_STAT: nxt_rdata = stat_ff;
      `FBC_OFF_ACT:  nxt_rdata = act_ff;
      `FBC_OFF_BE0:  nxt_rdata = be0_ff;
      `FBC_OFF_BE1:  nxt_rdata = be1_ff;
      `FBC_OFF_BE2:  nxt_rdata = be2_ff;
      `FBC_OFF_BE3:  nxt_rdata = be3_ff;
      default:       nxt_rdata = `FBC_UNMAPPED_RD;
    endcase
  end

  // Read data register and driver enable
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      rdata_ff <= `FBC_UNMAPPED_RD;
      rd_oe_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rd_oe_ff <= rd_act;
    end
  end

  assign O_HOST_RDATA    = rdata_ff;
  assign O_HOST_RDATA_OE = rd_oe_ff;

  // Format fixed per coefficient at load time
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      coef_ff      <= 9'h000;
      coef_addr_ff <= 7'h00;
      coef_wr_ff   <= 1'b0;
    end else begin
      coef_wr_ff <= I_COEF_WR;
      if (I_COEF_WR) begin
        coef_ff      <= {!stat_ff.coef_uns && I_COEF[7], I_COEF};
        coef_addr_ff <= I_COEF_ADDR;
      end
    end
  end

  assign O_COEF_WR   = coef_wr_ff;
  assign O_COEF_ADDR = coef_addr_ff;
  assign O_COEF_EXT  = coef_ff;

  // Sample extension; a live change mid-stream is not guarded
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      sample_ff <= 9'h000;
    end else begin
      sample_ff <= {!stat_ff.data_uns && I_SAMPLE[7], I_SAMPLE};
    end
  end

  assign O_SAMPLE_EXT = sample_ff;

  // Bypass path is two flops; normal path registers the last shift stage
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      chain_d1_ff  <= 8'h00;
      chain_out_ff <= 8'h00;
    end else begin
      chain_d1_ff  <= I_CHAIN_IN;
      chain_out_ff <= stat_ff.bypass ? chain_d1_ff : I_PSR_LAST;
    end
  end

  assign O_CHAIN_OUT = chain_out_ff;
  assign O_CHAIN_OE  = stat_ff.psr_oe;

  // Table output zero and static normaliser while host owns it
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      lut_x_ff   <= 8'h00;
      norm_ff    <= 5'h00;
      lut_add_ff <= 1'b0;
    end else begin
      lut_x_ff   <= act_ff.lut_en ? I_LUT_BYTE : 8'h00;
      norm_ff    <= (act_ff.lut_en && be3_ff.norm_dyn) ? I_LUT_NORM : be3_ff.norm;
      lut_add_ff <= act_ff.lut_en && be3_ff.lut_add;
    end
  end

  // Host ownership follows the bit at once; the host owes the settling wait
  assign O_LUT_HOST_OWN = !act_ff.lut_en;
  assign O_LUT_XFORM    = lut_x_ff;
  assign O_NORM_SHIFT   = norm_ff;
  assign O_LUT_TO_ADDER = lut_add_ff;

  fbc_backend #(
    .AW (AW)
  ) u_backend (
    .i_clk     (I_MCLK),
    .i_rst     (I_RST),
    .i_be0     (be0_ff),
    .i_mac     (I_MAC),
    .i_mac_vld (I_MAC_VALID),
    .i_cas_in  (I_CAS_IN),
    .o_res     (res),
    .o_res_vld (res_vld)
  );

  assign cmp = be1_ff.greater ? ($signed(res) > $signed(ext_ff)) : ($signed(res) < $signed(ext_ff));
  assign hit = res_vld && cmp;

  // Latch extreme only in tracking mode; a host load wins
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ext_ff <= '0;
    end else if (I_EXT_LOAD) begin
      ext_ff <= I_EXT_VAL;
    end else if (hit && !be1_ff.static_thr) begin
      ext_ff <= res;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      cnt_ff <= '0;
    end else if (hit) begin
      cnt_ff <= cnt_ff + HW'(1);
    end
  end

  assign O_EXTREME   = ext_ff;
  assign O_HIT_COUNT = cnt_ff;

  always_comb begin
    nxt_cas = res[CW-1:0];
    if (be2_ff.lo_pass) begin
      nxt_cas[`FBC_LO_LSB +: 8] = lut_x_ff;
    end
    if (be2_ff.hi_pass) begin
      nxt_cas[`FBC_HI_MSB -: 8] = lut_x_ff;
    end
  end

  // Cascade output register
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      cas_ff <= '0;
    end else begin
      cas_ff <= nxt_cas;
    end
  end

  assign O_CAS = cas_ff;
  assign O_CAS_OE = stat_ff.cas_en;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  property p_cas_float;
    wr_commit && lat_ff.addr == `FBC_OFF_STAT |=> O_CAS_OE == $past(lat_ff.wdata[4]);
  endproperty
  a_cas_float: assert property (p_cas_float) else $error("cascade driver enable does not follow its bit");

  property p_coef_fmt;
    I_COEF_WR |=> O_COEF_WR && O_COEF_EXT[8] == ($past(I_COEF[7]) && !$past(stat_ff.coef_uns));
  endproperty
  a_coef_fmt: assert property (p_coef_fmt) else $error("coefficient extended with wrong format");

  property p_coef_held;
    O_COEF_WR ##1 !I_COEF_WR && !O_COEF_WR |-> O_COEF_EXT == $past(O_COEF_EXT);
  endproperty
  a_coef_held: assert property (p_coef_held) else $error("loaded coefficient changed after load");

  property p_data_fmt;
    1'b1 |=> O_SAMPLE_EXT == {$past(I_SAMPLE[7]) && !$past(stat_ff.data_uns), $past(I_SAMPLE)};
  endproperty
  a_data_fmt: assert property (p_data_fmt) else $error("sample extended with wrong format");

  sequence s_bypass_held;
    stat_ff.bypass [*3];
  endsequence
  property p_bypass;
    s_bypass_held |-> O_CHAIN_OUT == $past(I_CHAIN_IN, 2);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path is not two clocks");

  property p_swap;
    stat_ff.swap && I_CYCLE_END && !wr_commit |=> O_BANK != $past(O_BANK);
  endproperty
  a_swap: assert property (p_swap) else $error("bank did not alternate in swap mode");

  property p_bank_fixed;
    !stat_ff.swap && !wr_commit |=> O_BANK == $past(O_BANK);
  endproperty
  a_bank_fixed: assert property (p_bank_fixed) else $error("bank moved without a write");

  property p_bank_base;
    O_BANK_BASE == (O_BANK ? 7'h40 : 7'h00);
  endproperty
  a_bank_base: assert property (p_bank_base) else $error("bank base address wrong");

  property p_rsv_read;
    rd_act && (req_s.addr == `FBC_OFF_ACT || req_s.addr == `FBC_OFF_BE1)
      |=> O_HOST_RDATA_OE && O_HOST_RDATA[7:2] == 6'h00;
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("reserved bits read nonzero");

  property p_lut_off;
    !act_ff.lut_en |-> O_LUT_HOST_OWN ##1 (O_LUT_XFORM == 8'h00 && O_NORM_SHIFT == $past(be3_ff.norm));
  endproperty
  a_lut_off: assert property (p_lut_off) else $error("table output leaked while host owns it");

  property p_static_thr;
    hit && be1_ff.static_thr && !I_EXT_LOAD |=> O_EXTREME == $past(O_EXTREME)
      && O_HIT_COUNT == $past(O_HIT_COUNT) + HW'(1);
  endproperty
  a_static_thr: assert property (p_static_thr) else $error("static threshold moved the extreme value");

  property p_track;
    res_vld && !be1_ff.static_thr && !I_EXT_LOAD && be1_ff.greater && $signed(res) > $signed(ext_ff)
      |=> O_EXTREME == $past(res);
  endproperty
  a_track: assert property (p_track) else $error("greater hit did not latch the result");

  property p_byte_mux;
    be2_ff.lo_pass && be2_ff.hi_pass |=> O_CAS[7:0] == $past(lut_x_ff) && O_CAS[21:14] == $past(lut_x_ff);
  endproperty
  a_byte_mux: assert property (p_byte_mux) else $error("table byte missing from cascade output");

  sequence s_wr_done;
    $rose(I_HOST_EN_N) && !$past(I_HOST_WR_N);
  endsequence
  property p_wr_lat;
    s_wr_done |-> ##[1:WR_LAT_MAX] wr_commit;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write not applied within three clocks");
endmodule

// ---- fbc_host_model.sv ----
// Purpose: Host processor on the asynchronous byte-wide register pins
// Assumes: Pins change just after a rising edge and hold until the answer
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/1ns
module fbc_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rdata_oe,
  output logic      [9:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_en_n,
  output logic            o_wr_n
);
  // Idle bus at time zero
  initial begin
    o_addr = 10'h3FF;
    o_wdata = 8'hFF;
    o_en_n = 1'b1;
    o_wr_n = 1'b1;
  end

  // Write: enable low three clocks, then high long enough to commit
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr_n <= 1'b0;
    o_en_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    o_en_n <= 1'b1;
    o_wr_n <= 1'b1;
    o_wdata <= ~d;
    o_addr <= ~a;
    repeat (5) @(posedge i_clk);
  endtask

  // Read: hold the request until the data enable is seen, bounded
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_clk);
    o_addr <= a;
    o_wr_n <= 1'b1;
    o_en_n <= 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge i_clk);
      if (i_rdata_oe === 1'b1) begin
        d = i_rdata;
        ok = 1'b1;
      end
    end
    o_en_n <= 1'b1;
    o_addr <= ~a;
    repeat (5) @(posedge i_clk);
  endtask
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the filter backend control block
// Assumes: Host model drives the register pins; bench drives the datapath
// Notes:   Statistics test runs right after the reset test, while the extreme register is known
`timescale 1ns/1ns
`include "fbc_consts.svh"
module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  haddr;
  logic [7:0]  hwdata, hrdata, smp, coef, chin, plast, lbyte, d;
  logic        hen_n, hwr_n, hoe, ce = 1'b0, cwr = 1'b0, vld = 1'b0, ok;
  logic [23:0] mac = 24'h0, cin = 24'h0;
  logic [8:0]  sx, cx;
  logic [7:0]  chout;
  logic [21:0] cas;
  int          num_errors = 0;
  int          total_checks = 0;
  wire logic [23:0] extr;
  wire logic [21:0] hits;
  wire logic        cas_oe, bank, own, cwr_o, choe, lta;
  wire logic [6:0]  base, cad;
  wire logic [4:0]  nsh;
  logic      [4:0]  lnorm = 5'h0A;

  // Half period of 50 ns gives 10 MHz
  always #50 mclk = ~mclk;

  fbc_host_model host_u (.i_clk(mclk), .i_rdata(hrdata), .i_rdata_oe(hoe), .o_addr(haddr),
    .o_wdata(hwdata), .o_en_n(hen_n), .o_wr_n(hwr_n));

  fbc_ctrl dut_u (.I_MCLK(mclk), .I_RST(rst), .I_HOST_ADDR(haddr), .I_HOST_WDATA(hwdata),
    .I_HOST_EN_N(hen_n), .I_HOST_WR_N(hwr_n), .O_HOST_RDATA(hrdata), .O_HOST_RDATA_OE(hoe),
    .I_SAMPLE(smp), .I_CYCLE_END(ce), .O_SAMPLE_EXT(sx), .I_COEF_WR(cwr), .I_COEF_ADDR(7'h05),
    .I_COEF(coef), .O_COEF_WR(cwr_o), .O_COEF_ADDR(cad), .O_COEF_EXT(cx), .O_BANK(bank),
    .O_BANK_BASE(base), .I_CHAIN_IN(chin), .I_PSR_LAST(plast), .O_CHAIN_OUT(chout),
    .O_CHAIN_OE(choe), .O_LUT_HOST_OWN(own), .I_LUT_BYTE(lbyte), .I_LUT_NORM(lnorm),
    .O_LUT_XFORM(d), .O_NORM_SHIFT(nsh), .O_LUT_TO_ADDER(lta), .I_MAC(mac), .I_MAC_VALID(vld),
    .I_CAS_IN(cin), .O_CAS(cas), .O_CAS_OE(cas_oe), .I_EXT_LOAD(1'b0), .I_EXT_VAL(24'h0),
    .O_EXTREME(extr), .O_HIT_COUNT(hits));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Register read with bounded wait
  task automatic rc(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] r;
    host_u.rd(a, r, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t read timeout", $time);
      tally_and_finish();
    end else begin
      chk(r, e);
    end
  endtask

  // One mac word; cascade output checked three clocks on
  task automatic mw(input logic [23:0] m, input logic [21:0] e);
    mac <= m;
    vld <= 1'b1;
    cyc(1);
    vld <= 1'b0;
    cyc(2);
    chk(cas, e);
  endtask

  initial begin
    smp = 8'h00;
    coef = 8'h00;
    chin = 8'h00;
    plast = 8'h00;
    lbyte = 8'hA5;
    cyc(20);
    rst <= 1'b0;
    cyc(1);
    rc(`FBC_OFF_STAT, 8'h00);
    rc(`FBC_OFF_ACT, 8'h00);
    rc(`FBC_OFF_BE0, 8'h00);
    chk(cas_oe, 1'b0);
    chk(own, 1'b1);
    chk(d, 8'h00);
    $display("test reset done");
    host_u.wr(`FBC_OFF_BE1, 8'h01);
    cyc(1);
    mw(24'h00000A, 22'h00000A);
    chk(hits, 22'h1);
    chk(extr, 24'h00000A);
    host_u.wr(`FBC_OFF_BE1, 8'hFF);
    rc(`FBC_OFF_BE1, 8'h03);
    cyc(1);
    mw(24'h000014, 22'h000014);
    chk(hits, 22'h2);
    chk(extr, 24'h00000A);
    $display("test statistics done");
    host_u.wr(`FBC_OFF_BE0, 8'h81);
    mw(24'hFFFFFB, 22'h000005);
    host_u.wr(`FBC_OFF_BE0, 8'hC1);
    mw(24'hFFFFFB, 22'h000005);
    host_u.wr(`FBC_OFF_BE0, 8'h41);
    mw(24'hFFFFFB, 22'h000000);
    mw(24'h000007, 22'h000007);
    host_u.wr(`FBC_OFF_BE0, 8'h05);
    mw(24'h000040, 22'h000010);
    host_u.wr(`FBC_OFF_BE0, 8'h3D);
    mw(24'h000040, 22'h000100);
    cin <= 24'h000003;
    host_u.wr(`FBC_OFF_BE0, 8'h01);
    mw(24'h000010, 22'h000010);
    host_u.wr(`FBC_OFF_BE0, 8'h00);
    mw(24'h000010, 22'h000013);
    $display("test backend done");
    host_u.wr(`FBC_OFF_BE2, 8'hFF);
    rc(`FBC_OFF_BE2, 8'h7F);
    host_u.wr(`FBC_OFF_BE3, 8'hFE);
    chk(nsh, 5'h1F);
    chk(lta, 1'b0);
    host_u.wr(`FBC_OFF_ACT, 8'hFF);
    rc(`FBC_OFF_ACT, 8'h03);
    chk(own, 1'b0);
    chk(lta, 1'b1);
    chk(bank, 1'b1);
    chk(base, 7'h40);
    mw(24'h000000, 22'h2940A5);
    rc(10'h3F0, 8'h00);
    $display("test registers done");
    // data format changed only while idle
    host_u.wr(`FBC_OFF_STAT, 8'hFF);
    rc(`FBC_OFF_STAT, 8'h3F);
    chk(cas_oe, 1'b1);
    chk(choe, 1'b1);
    smp <= 8'h80;
    coef <= 8'hFF;
    cwr <= 1'b1;
    cyc(1);
    cwr <= 1'b0;
    cyc(1);
    chk(sx, 9'h080);
    chk(cx, 9'h0FF);
    chk(cwr_o, 1'b1);
    chk(cad, 7'h05);
    chin <= 8'h5A;
    cyc(2);
    chk(chout, 8'h00);
    cyc(1);
    chk(chout, 8'h5A);
    // bank toggles on cycle end once swap runs
    host_u.wr(`FBC_OFF_STAT, 8'h01);
    chk(bank, 1'b1);
    coef <= 8'hFF;
    cwr <= 1'b1;
    plast <= 8'h33;
    ce <= 1'b1;
    cyc(1);
    cwr <= 1'b0;
    ce <= 1'b0;
    cyc(1);
    chk(cx, 9'h1FF);
    chk(sx, 9'h180);
    chk(chout, 8'h33);
    chk(bank, 1'b0);
    chk(base, 7'h00);
    host_u.wr(`FBC_OFF_STAT, 8'h00);
    ce <= 1'b1;
    cyc(1);
    ce <= 1'b0;
    cyc(1);
    chk(bank, 1'b0);
    $display("test formats and banks done");
    tally_and_finish();
  end
endmodule
